// [inc/osc_pkg.sv]
// Oscillator source configuration and control: shared constants and types.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package osc_pkg;

    // Register byte offsets
    localparam logic [11:0] OSC_SEL_CFG_OFS = 12'h000;
    localparam logic [11:0] OSC_MODE_CFG_OFS = 12'h004;
    localparam logic [11:0] OSC_CTRL_OFS = 12'h008;
    localparam logic [11:0] OSC_TUNE_OFS = 12'h00c;
    localparam logic [11:0] OSC_UNLOCK_OFS = 12'h010;
    localparam logic [11:0] OSC_STATUS_OFS = 12'h014;

    // Unlock keys, written in order to the unlock register
    localparam logic [15:0] OSC_KEY1 = 16'h0046;
    localparam logic [15:0] OSC_KEY2 = 16'h0057;

    // Configuration word field positions
    localparam int OSC_TWO_SPEED_STARTUP_OPT_BIT = 7;
    localparam int OSC_INITIAL_SOURCE_SEL_LSB = 0;
    localparam int OSC_SWITCH_MONITOR_MODE_LSB = 6;
    localparam int OSC_IOL1_BIT = 5;
    localparam int OSC_FUNC_BIT = 2;
    localparam int OSC_POSC_LSB = 0;
    localparam logic [15:0] OSC_SEL_UNUSED = 16'hff78;
    localparam logic [15:0] OSC_MODE_UNUSED = 16'hff18;

    // Control register field positions
    localparam int OSC_CURRENT_SOURCE_SEL_LSB = 12;
    localparam int OSC_NEW_SOURCE_SEL_LSB = 8;
    localparam int OSC_CLOCK_SOURCE_LOCK_BIT = 7;
    localparam int OSC_PINSEL_LOCK_BIT = 6;
    localparam int OSC_LOCK_BIT = 5;
    localparam int OSC_CF_BIT = 3;
    localparam int OSC_SOSCEN_BIT = 1;
    localparam int OSC_SWITCH_REQUEST_BIT = 0;

    // Tuning: 6-bit signed, 0.375 percent per step, range -12..+11.625
    localparam int OSC_TUNE_W = 6;
    localparam logic [5:0] OSC_TUNE_RST = 6'h00;

    // Timing counts
    localparam int OSC_CLK_MHZ = 200;
    localparam int OSC_SETTLE_NS = 100;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * OSC_CLK_MHZ + 999) / 1000;

    // Clock source encodings
    typedef enum logic [2:0] {
        SRC_FRC = 3'h0,
        SRC_FRC_PLL = 3'h1,
        SRC_PRI = 3'h2,
        SRC_PRI_PLL = 3'h3,
        SRC_SEC = 3'h4,
        SRC_LOW_POWER_RC_OSC = 3'h5,
        SRC_FRC_DIV16 = 3'h6,
        SRC_FRC_DIVN = 3'h7
    } osc_src_t;

    // Primary oscillator mode encodings
    typedef enum logic [1:0] {
        POSC_EXT = 2'h0,
        POSC_XTAL = 2'h1,
        POSC_HS = 2'h2,
        POSC_OFF = 2'h3
    } osc_posc_t;

    // Nonvolatile configuration straps
    typedef struct packed {
        logic two_speed_startup_opt;
        osc_src_t initial_source_sel;
        logic [1:0] switch_monitor_mode;
        logic pinsel_single_reconfig;
        logic clkout_pin_function;
        osc_posc_t primary_osc_mode;
    } osc_cfg_t;

    // Status from the analog oscillator and monitor blocks
    typedef struct packed {
        logic pll_locked;
        logic pll_timer_done;
        logic pll_enabled;
        logic source_ready;
        logic fail_detect;
    } osc_stat_t;

    // Controls driven to the clock mux and pads
    typedef struct packed {
        osc_src_t active_src;
        logic monitor_en;
        logic secondary_osc_enable;
        logic [5:0] fast_rc_tuning;
        logic clkout_fcy;
        logic clkout_gpio;
        logic pinsel_lock;
        logic pinsel_wr_allow;
    } osc_ctl_t;

endpackage

// [src/osc_ctrl.sv]
// Oscillator source configuration and run-time control with an APB slave.
// Assumes config straps are stable after power-on and status inputs are
// synchronous to pclk; presetn is the power-on reset only.
//
// Overview of operation
// [RL1] Two-speed startup: run fast RC, then switch
// [RL2] Startup bit clear: start on chosen source
// [RL3] Initial source field selects power-on source
// [RL4] Unused config bits program and read one
// [RL5] Switch mode field gates switching and monitor
// [RL6] Pin-select single or multiple reconfiguration
// [RL7] Clock-out pin: cycle clock or GPIO
// [RL8] Primary mode: off, HS, crystal, external
// [RL9] Control and tuning reset only by power-on
// [RL10] Tuning trims fast RC by twelve percent
// [RL11] Current source field is read-only
// [RL12] New source field holds switch target
// [RL13] Power-on loads current and new source
// [RL14] Clock lock bit freezes source; honoured only when switch mode field is 01
// [RL15] Pin-select lock blocks pin-select writes
// [RL16] PLL lock bit reports lock or timer
// [RL17] Control writes need an unlock sequence
// [RL18] No direct PLL-to-PLL switch by software; not enforced, any new source is taken
// [RL19] Clock fail flag sticky until cleared
// [RL20] Switch request clears when switch completes
// [RL21] Disabled or locked switching ignores requests
////////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps

module osc_ctrl
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire osc_pkg::osc_cfg_t cfg,
    input wire osc_pkg::osc_stat_t stat,
    output osc_pkg::osc_ctl_t ctl
);
    import osc_pkg::*;

    typedef enum logic [1:0] {
        ST_POR,
        ST_RUN,
        ST_WAIT
    } osc_state_t;

    typedef enum logic [1:0] {
        UL_IDLE,
        UL_KEY1,
        UL_OPEN
    } osc_unlock_t;

    typedef struct packed {
        osc_state_t st;
        osc_unlock_t ul;
        osc_src_t cur;
        osc_src_t target;
        osc_src_t new_source_sel;
        logic clk_lock;
        logic pin_lock;
        logic pin_locked_once;
        logic fail;
        logic sosc_en;
        logic req;
        logic rd_ph;
        logic [5:0] tune;
        logic [7:0] settle;
        logic [31:0] rdata;
    } osc_state_s_t;

    osc_state_s_t s_q;
    osc_state_s_t s_d;

    // Switching allowed by mode field and lock bit
    function automatic logic switch_ok(input logic [1:0] mode, input logic lk);
        switch_ok = !mode[1] && !(mode == 2'b01 && lk);
    endfunction

    logic acc;
    logic wr;
    logic [15:0] ctrl_rd;
    logic [15:0] sel_rd;
    logic [15:0] mode_rd;
    logic pll_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Readback words
    assign pll_ok = stat.pll_enabled && (stat.pll_locked || stat.pll_timer_done); // [RL16]
    assign sel_rd = OSC_SEL_UNUSED
        | (16'(cfg.two_speed_startup_opt) << OSC_TWO_SPEED_STARTUP_OPT_BIT)
        | (16'(cfg.initial_source_sel) << OSC_INITIAL_SOURCE_SEL_LSB); // [RL4]
    assign mode_rd = OSC_MODE_UNUSED
        | (16'(cfg.switch_monitor_mode) << OSC_SWITCH_MONITOR_MODE_LSB)
        | (16'(cfg.pinsel_single_reconfig) << OSC_IOL1_BIT)
        | (16'(cfg.clkout_pin_function) << OSC_FUNC_BIT)
        | (16'(cfg.primary_osc_mode) << OSC_POSC_LSB); // [RL4]
    assign ctrl_rd = (16'(s_q.cur) << OSC_CURRENT_SOURCE_SEL_LSB)
        | (16'(s_q.new_source_sel) << OSC_NEW_SOURCE_SEL_LSB)
        | (16'(s_q.clk_lock) << OSC_CLOCK_SOURCE_LOCK_BIT)
        | (16'(s_q.pin_lock) << OSC_PINSEL_LOCK_BIT)
        | (16'(pll_ok) << OSC_LOCK_BIT)
        | (16'(s_q.fail) << OSC_CF_BIT)
        | (16'(s_q.sosc_en) << OSC_SOSCEN_BIT)
        | (16'(s_q.req) << OSC_SWITCH_REQUEST_BIT); // [RL11]

    // APB handshake: writes finish at once, reads add one wait state so that
    // the registered read data already stands when pready is sampled high
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign pready = !(acc && !pwrite) || s_q.rd_ph;
    assign prdata = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        pslverr = 1'b0;
        // Power-on: load sources from straps
        if (s_q.st == ST_POR)
        begin
            s_d.new_source_sel = cfg.initial_source_sel; // [RL13]
            s_d.target = cfg.initial_source_sel;
            if (cfg.two_speed_startup_opt)
            begin
                s_d.cur = SRC_FRC; // [RL1]
                s_d.st = ST_WAIT;
                s_d.settle = 8'(OSC_SETTLE_CYC);
            end
            else
            begin
                s_d.cur = cfg.initial_source_sel; // [RL2] [RL3] [RL13]
                s_d.st = ST_RUN;
            end
        end
        // Switch in progress: wait for the new source, then settle
        else if (s_q.st == ST_WAIT)
        begin
            if (!stat.source_ready)
                s_d.settle = 8'(OSC_SETTLE_CYC);
            else if (s_q.settle != 8'h00)
                s_d.settle = s_q.settle - 8'h01;
            else
            begin
                s_d.cur = s_q.target; // [RL1]
                s_d.req = 1'b0; // [RL20]
                s_d.st = ST_RUN;
            end
        end
        else if (s_q.req)
        begin
            if (switch_ok(cfg.switch_monitor_mode, s_q.clk_lock))
            begin
                s_d.target = s_q.new_source_sel; // [RL12]
                s_d.st = ST_WAIT;
                s_d.settle = 8'(OSC_SETTLE_CYC);
            end
            else
                s_d.req = 1'b0; // [RL21]
        end

        // Register reads: first access cycle loads the data, second presents it
        s_d.rd_ph = acc && !pwrite && !s_q.rd_ph;
        if (acc && !pwrite)
        begin
            if (paddr == OSC_SEL_CFG_OFS)
                s_d.rdata = 32'(sel_rd);
            else if (paddr == OSC_MODE_CFG_OFS)
                s_d.rdata = 32'(mode_rd);
            else if (paddr == OSC_CTRL_OFS)
                s_d.rdata = 32'(ctrl_rd);
            else if (paddr == OSC_TUNE_OFS)
                s_d.rdata = 32'(s_q.tune);
            else if (paddr == OSC_STATUS_OFS)
                s_d.rdata = 32'({s_q.ul == UL_OPEN, s_q.st == ST_WAIT});
            else
            begin
                s_d.rdata = 32'h0;
                pslverr = 1'b1;
            end
        end

        // Unlock sequence: two keys, then one control write
        if (wr && paddr == OSC_UNLOCK_OFS)
        begin
            if (pwdata[15:0] == OSC_KEY1)
                s_d.ul = UL_KEY1;
            else if (pwdata[15:0] == OSC_KEY2 && s_q.ul == UL_KEY1)
                s_d.ul = UL_OPEN;
            else
                s_d.ul = UL_IDLE;
        end
        else if (wr && paddr == OSC_CTRL_OFS)
        begin
            s_d.ul = UL_IDLE;
            if (s_q.ul == UL_OPEN) // [RL17]
            begin
                if (s_q.st != ST_WAIT)
                    s_d.new_source_sel = osc_src_t'(pwdata[OSC_NEW_SOURCE_SEL_LSB +: 3]); // [RL12]
                if (!s_q.clk_lock || cfg.switch_monitor_mode != 2'b01)
                    s_d.clk_lock = pwdata[OSC_CLOCK_SOURCE_LOCK_BIT]; // [RL14]
                // Single-reconfig policy: once locked, stays locked
                if (!(cfg.pinsel_single_reconfig && s_q.pin_locked_once))
                    s_d.pin_lock = pwdata[OSC_PINSEL_LOCK_BIT]; // [RL6]
                if (pwdata[OSC_PINSEL_LOCK_BIT])
                    s_d.pin_locked_once = 1'b1;
                s_d.sosc_en = pwdata[OSC_SOSCEN_BIT];
                if (pwdata[OSC_SWITCH_REQUEST_BIT])
                    s_d.req = 1'b1; // [RL20]
                if (!pwdata[OSC_CF_BIT])
                    s_d.fail = 1'b0; // [RL19]
            end
        end
        else if (wr && paddr == OSC_TUNE_OFS)
            s_d.tune = pwdata[OSC_TUNE_W-1:0]; // [RL10]
        else if (wr && paddr != OSC_SEL_CFG_OFS && paddr != OSC_MODE_CFG_OFS
                 && paddr != OSC_STATUS_OFS)
            pslverr = 1'b1;

        // Failure detection wins over a clear in the same cycle
        if (stat.fail_detect && cfg.switch_monitor_mode == 2'b00)
            s_d.fail = 1'b1; // [RL19] [RL5]
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register: cleared only by power-on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0; // [RL9]
            s_q.st <= ST_POR;
            s_q.ul <= UL_IDLE;
            s_q.tune <= OSC_TUNE_RST;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to clock mux, pads and pin-select logic
    always_comb
    begin
        ctl.active_src = s_q.cur;
        ctl.monitor_en = (cfg.switch_monitor_mode == 2'b00); // [RL5]
        ctl.secondary_osc_enable = s_q.sosc_en;
        ctl.fast_rc_tuning = s_q.tune; // [RL10]
        // Pin is free unless primary runs a crystal mode
        ctl.clkout_fcy = 1'b0;
        ctl.clkout_gpio = 1'b0;
        if (cfg.primary_osc_mode != POSC_XTAL && cfg.primary_osc_mode != POSC_HS) // [RL8]
        begin
            ctl.clkout_fcy = cfg.clkout_pin_function; // [RL7]
            ctl.clkout_gpio = !cfg.clkout_pin_function; // [RL7]
        end
        ctl.pinsel_lock = s_q.pin_lock;
        ctl.pinsel_wr_allow = !s_q.pin_lock; // [RL15]
    end

endmodule

// [test/osc_ctrl_asserts.sv]
// Checker for the oscillator control block: config reads, pin roles, sources.
// Assumes it is bound into osc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module osc_ctrl_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire osc_pkg::osc_cfg_t cfg,
    input wire osc_pkg::osc_stat_t stat,
    input wire osc_pkg::osc_ctl_t ctl
);
    import osc_pkg::*;
    logic rd_q;
    logic bad;
    // Read access and unmapped address decode
    assign rd_q = psel && penable && !pwrite;
    assign bad = paddr > OSC_STATUS_OFS || paddr[1:0] != 2'h0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    chk_monitor_mode: assert property (ctl.monitor_en == (cfg.switch_monitor_mode == 2'h0))
        else $error("monitor enable wrong");
    chk_clkout_role: assert property (ctl.clkout_fcy == (cfg.clkout_pin_function
        && !(cfg.primary_osc_mode inside {POSC_XTAL, POSC_HS}))) else $error("clkout role wrong");
    chk_pinsel_allow: assert property (ctl.pinsel_wr_allow != ctl.pinsel_lock)
        else $error("pin-select allow wrong");
    chk_src_held: assert property (cfg.switch_monitor_mode[1] && !cfg.two_speed_startup_opt
        && $past(presetn) |=> $stable(ctl.active_src)) else $error("source moved");
    chk_por_load: assert property ($rose(presetn) |=> ctl.active_src ==
        (cfg.two_speed_startup_opt ? SRC_FRC : cfg.initial_source_sel)) else $error("por load");
    chk_lock_read: assert property (rd_q && paddr == OSC_CTRL_OFS |=> prdata[OSC_LOCK_BIT] ==
        $past(stat.pll_enabled && (stat.pll_locked || stat.pll_timer_done))) else $error("lock bit");
    chk_sel_read: assert property (rd_q && paddr == OSC_SEL_CFG_OFS |=> prdata == {16'h0,
        OSC_SEL_UNUSED | {8'h0, cfg.two_speed_startup_opt, 4'h0, cfg.initial_source_sel}})
        else $error("sel config read");
    chk_mode_read: assert property (rd_q && paddr == OSC_MODE_CFG_OFS |=> prdata == {16'h0,
        OSC_MODE_UNUSED | {8'h0, cfg.switch_monitor_mode, cfg.pinsel_single_reconfig, 2'h0,
        cfg.clkout_pin_function, cfg.primary_osc_mode}}) else $error("mode config read");
    chk_unmapped_err: assert property (rd_q && bad |-> pslverr ##1 prdata == 32'h0)
        else $error("unmapped read");
endmodule
bind osc_ctrl osc_ctrl_asserts u_osc_ctrl_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg), .stat(stat), .ctl(ctl));

// [test/test_osc_ctrl.sv]
// Testbench for the oscillator control block, driven over APB.
// Assumes the checker is bound in; straps and status are driven here.
`timescale 1ns/1ps
module test_osc_ctrl;
    import osc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    osc_cfg_t cfg = '{1'b0, SRC_PRI, 2'h0, 1'b1, 1'b1, POSC_EXT};
    osc_stat_t stat = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    osc_ctl_t ctl;
    int mismatches = 0;
    int n_checks = 0;
    osc_ctrl u_osc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .stat(stat), .ctl(ctl));
    // Clock at 200 MHz
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and shared compare
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data is taken at the edge where pready is high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            r = prdata;
            if (pready === 1'b1)
                break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50)
        begin
            mismatches++;
            end_of_test();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    // Control write preceded by the two unlock keys
    task automatic ctl_wr(input logic [31:0] d);
        wr(OSC_UNLOCK_OFS, {16'h0, OSC_KEY1});
        wr(OSC_UNLOCK_OFS, {16'h0, OSC_KEY2});
        wr(OSC_CTRL_OFS, d);
    endtask
    task automatic wait_src(input osc_src_t s);
        int i;
        for (i = 0; i < 100 && ctl.active_src !== s; i++)
            @(posedge pclk);
        chk({29'h0, ctl.active_src}, {29'h0, s});
        if (i == 100)
            end_of_test();
    endtask
    task automatic por();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        por();
        rd(OSC_SEL_CFG_OFS, 32'h0000ff7a);
        rd(OSC_MODE_CFG_OFS, 32'h0000ff3c);
        rd(OSC_CTRL_OFS, 32'h00002200);
        wr(OSC_CTRL_OFS, 32'h00007001);
        rd(OSC_CTRL_OFS, 32'h00002200);
        ctl_wr(32'h00007001);
        wait_src(SRC_FRC);
        rd(OSC_CTRL_OFS, 32'h00000000);
        stat.pll_locked <= 1'b1;
        rd(OSC_CTRL_OFS, 32'h00000020);
        stat.pll_enabled <= 1'b0;
        rd(OSC_CTRL_OFS, 32'h00000000);
        stat.fail_detect <= 1'b1;
        @(posedge pclk);
        stat.fail_detect <= 1'b0;
        rd(OSC_CTRL_OFS, 32'h00000008);
        ctl_wr(32'h00000000);
        rd(OSC_CTRL_OFS, 32'h00000000);
        ctl_wr(32'h00000040);
        chk({30'h0, ctl.pinsel_lock, ctl.pinsel_wr_allow}, 32'h2);
        ctl_wr(32'h00000000);
        rd(OSC_CTRL_OFS, 32'h00000040);
        wr(OSC_TUNE_OFS, 32'h00000020);
        chk({26'h0, ctl.fast_rc_tuning}, 32'h20);
        rd(12'h040, 32'h00000000);
        cfg.switch_monitor_mode <= 2'h2;
        por();
        chk({26'h0, ctl.fast_rc_tuning}, 32'h0);
        rd(OSC_CTRL_OFS, 32'h00002200);
        ctl_wr(32'h00000001);
        repeat (OSC_SETTLE_CYC + 10) @(posedge pclk);
        chk({29'h0, ctl.active_src}, {29'h0, SRC_PRI});
        cfg.two_speed_startup_opt <= 1'b1;
        cfg.switch_monitor_mode <= 2'h1;
        por();
        chk({29'h0, ctl.active_src}, {29'h0, SRC_FRC});
        wait_src(SRC_PRI);
        ctl_wr(32'h00000280);
        ctl_wr(32'h00000081);
        repeat (OSC_SETTLE_CYC + 10) @(posedge pclk);
        chk({29'h0, ctl.active_src}, {29'h0, SRC_PRI});
        end_of_test();
    end
endmodule
